// ==== common/epwm_pkg.sv ====
package epwm_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_MODULE_CONTROL  = 8'h00;
    localparam logic [7:0] OFF_DUTY_HIGH_BYTE  = 8'h04;
    localparam logic [7:0] OFF_PERIOD_REGISTER = 8'h08;
    localparam logic [7:0] OFF_PWM_CONTROL     = 8'h0C;
    localparam logic [7:0] OFF_SHUTDOWN_CTRL   = 8'h10;
    localparam logic [7:0] OFF_TIMER_TWO_CTRL  = 8'h14;
    localparam logic [7:0] OFF_TIMER_TWO       = 8'h18;
    localparam logic [7:0] OFF_PERIPH_FLAGS    = 8'h1C;
    localparam logic [7:0] OFF_PORT_C_DIR      = 8'h20;
    localparam logic [7:0] OFF_CLOCK_STATUS    = 8'h24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MC_MODE_LSB   = 0;   // mode_polarity_field <3:0>
    localparam int MC_DCLOW_LSB  = 4;   // duty low bits <5:4>
    localparam int MC_CONFIG_LSB = 6;   // output_config_field <7:6>
    localparam int PC_DEAD_LSB   = 0;   // dead band <6:0>
    localparam int PC_RESTART    = 7;   // auto_restart_enable
    localparam int SC_BD_LSB     = 0;   // pair_bd_shutdown_state <1:0>
    localparam int SC_AC_LSB     = 2;   // pair_ac_shutdown_state <3:2>
    localparam int SC_SRC_LSB    = 4;   // source select <6:4>
    localparam int SC_STATUS     = 7;   // shutdown_event_status
    localparam int TC_PRE_LSB    = 0;   // timer_prescale_select <1:0>
    localparam int TC_RUN        = 2;   // timer_two_run
    localparam int PF_TIMER_FLAG = 1;   // timer_two_flag

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_PERIOD    = 8'hFF;
    localparam logic [3:0] RST_PORT_DIR  = 4'hF;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CFG_SINGLE    = 2'h0;
    localparam logic [1:0] CFG_FULL_FWD  = 2'h1;
    localparam logic [1:0] CFG_HALF      = 2'h2;
    localparam logic [1:0] CFG_FULL_REV  = 2'h3;
    localparam logic [1:0] PWM_MODE_TOP  = 2'h3;   // mode<3:2> = 11 selects PWM
    localparam logic [1:0] PRE_DIV1      = 2'h0;
    localparam logic [1:0] PRE_DIV4      = 2'h1;

    typedef struct packed {
        logic output_pin_a;
        logic output_pin_b;
        logic output_pin_c;
        logic output_pin_d;
    } epwm_pins_type;

    typedef struct packed {
        logic comparator_1;
        logic comparator_2;
        logic ext_pin_low;
    } epwm_sources_type;

endpackage

// ==== hw/epwm_timer.sv ====
module epwm_timer #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic             run,
    input  wire logic [1:0]       prescale,
    input  wire logic [WIDTH-1:0] period,
    output logic      [WIDTH-1:0] count,
    output logic      [1:0]       fine,
    output logic                  period_start
);
    // ------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------
    logic [3:0] pre_cnt;
    logic [3:0] pre_max;
    logic       tick;

    // Divide by 1, 4 or 16; codes 2 and 3 both divide by 16
    always_comb
    begin
        case (prescale)
            epwm_pkg::PRE_DIV1: pre_max = 4'h0;
            epwm_pkg::PRE_DIV4: pre_max = 4'h3;
            default:            pre_max = 4'hF;
        endcase
    end

    assign tick = run && (pre_cnt >= pre_max);
    assign fine = pre_cnt[1:0];

    // Prescaler only advances while the run bit is set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_cnt <= 4'h0;
        else if (clk_en && run)                              // see [RULE_14]
            pre_cnt <= tick ? 4'h0 : pre_cnt + 4'h1;
    end

    // Match against period clears the count on the next tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count        <= '0;
            period_start <= 1'b0;
        end
        else if (clk_en)
        begin
            period_start <= 1'b0;
            if (tick)
            begin
                if (count == period)                         // see [RULE_20]
                begin
                    count        <= '0;
                    period_start <= 1'b1;                    // see [RULE_05]
                end
                else
                    count <= count + 1'b1;
            end
        end
    end
endmodule

// ==== hw/epwm_steer.sv ====
module epwm_steer #(
    parameter int DEAD_WIDTH = 7
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    input  wire logic                  active,
    input  wire logic                  duty_on,
    input  wire logic [1:0]            config_sel,
    input  wire logic [DEAD_WIDTH-1:0] dead_band,
    output epwm_pkg::epwm_pins_type    level
);
    // ------------------------------------------------------------
    // Half-bridge dead band: rising edges are held off
    // ------------------------------------------------------------
    logic [1:0]            raw;
    logic [1:0]            dly;
    logic [DEAD_WIDTH-1:0] dcnt [2];

    assign raw = {~duty_on, duty_on};

    for (genvar i = 0; i < 2; i++)
    begin : g_dead
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                dcnt[i] <= '0;
                dly[i]  <= 1'b0;
            end
            else if (clk_en)
            begin
                if (!raw[i] || !active)
                begin
                    dcnt[i] <= '0;
                    dly[i]  <= 1'b0;
                end
                else if (dcnt[i] >= dead_band)               // see [RULE_09]
                    dly[i]  <= 1'b1;
                else
                    dcnt[i] <= dcnt[i] + 1'b1;
            end
        end
    end

    // Active-high pin functions before polarity is applied
    always_comb
    begin
        level = '0;
        case (config_sel)                                    // see [RULE_06]
            epwm_pkg::CFG_SINGLE:
                level.output_pin_a = duty_on;
            epwm_pkg::CFG_FULL_FWD:
            begin
                level.output_pin_a = 1'b1;
                level.output_pin_d = duty_on;
            end
            epwm_pkg::CFG_HALF:
            begin
                level.output_pin_a = dly[0];
                level.output_pin_b = dly[1];
            end
            default:
            begin
                level.output_pin_c = 1'b1;
                level.output_pin_b = duty_on;
            end
        endcase
        if (!active)
            level = '0;
    end
endmodule

// ==== hw/epwm_unit.sv ====
// Operation
// [RULE_01] Keep running when clock fails, on backup oscillator
// [RULE_02] Any reset: pins input, registers default
// [RULE_03] Reset state behaves like the plain unit
// [RULE_04] Software holds pins as inputs first
// [RULE_05] Period length comes from period register
// [RULE_06] Config field picks output arrangement and direction
// [RULE_07] Mode field picks output polarities
// [RULE_08] Duty is high byte plus two low bits
// [RULE_09] Half-bridge dead band from control bits 6:0
// [RULE_10] Source field picks shutdown trigger events
// [RULE_11] Pair fields pick pin levels in shutdown
// [RULE_12] Status bit set holds outputs shut down
// [RULE_13] Auto-restart bit lets unit recover itself
// [RULE_14] Timer prescale bits 1:0, runs with bit 2
// [RULE_15] Timer flag sets on overflow, software clears
// [RULE_16] Software enables pins after new cycle starts
// [RULE_17] Software sets comparators and analog inputs
// [RULE_18] Auto-restart clears status; resume at next period
// [RULE_19] Status writes ignored while condition active
// [RULE_20] Timer resets cycle after matching period
module epwm_unit #(
    parameter int TIMER_WIDTH = 8,
    parameter int DEAD_WIDTH  = 7
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       clk_en,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire epwm_pkg::epwm_sources_type shutdown_sources,
    input  wire logic                       fail_monitor_enable,
    input  wire logic                       primary_clock_fail,
    output logic                            backup_clock_select,
    output epwm_pkg::epwm_pins_type         pin_out,
    output epwm_pkg::epwm_pins_type         pin_oe,
    output logic                            timer_two_flag
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0]             module_control;
    logic [7:0]             duty_high_byte;
    logic [TIMER_WIDTH-1:0] period_register;
    logic [7:0]             pwm_control;
    logic [6:0]             shutdown_setup;
    logic                   shutdown_event_status;
    logic [2:0]             timer_two_control;
    logic [3:0]             port_c_direction;

    logic                   wr_en;
    logic                   rd_en;
    logic                   mapped;
    logic [TIMER_WIDTH-1:0] timer_two;
    logic [1:0]             fine;
    logic                   period_start;
    logic                   shutdown_cond;
    logic                   pwm_mode;
    logic                   duty_on;
    epwm_pkg::epwm_pins_type level;
    epwm_pkg::epwm_pins_type next_out;
    epwm_pkg::epwm_pins_type next_oe;

    typedef enum logic [2:0] {
        EPWM_RUN   = 3'b001,
        EPWM_SHUT  = 3'b010,
        EPWM_ARMED = 3'b100
    } epwm_state_type;

    epwm_state_type state;

    // Field accessors used in several places
    function automatic logic [1:0] pair_state(input logic [6:0] s, input int lsb);
        pair_state = s[lsb +: 2];
    endfunction

    function automatic logic is_off(input logic [7:0] a);
        is_off = (a[7:0] == paddr);
    endfunction

    // ------------------------------------------------------------
    // APB slave: one wait state, error on unmapped address
    // ------------------------------------------------------------
    always_comb
    begin
        mapped = is_off(epwm_pkg::OFF_MODULE_CONTROL)  || is_off(epwm_pkg::OFF_DUTY_HIGH_BYTE)
              || is_off(epwm_pkg::OFF_PERIOD_REGISTER) || is_off(epwm_pkg::OFF_PWM_CONTROL)
              || is_off(epwm_pkg::OFF_SHUTDOWN_CTRL)   || is_off(epwm_pkg::OFF_TIMER_TWO_CTRL)
              || is_off(epwm_pkg::OFF_TIMER_TWO)       || is_off(epwm_pkg::OFF_PERIPH_FLAGS)
              || is_off(epwm_pkg::OFF_PORT_C_DIR)      || is_off(epwm_pkg::OFF_CLOCK_STATUS);
    end

    // The access completes at the edge where pready is already high
    assign wr_en = psel && penable && pready && pwrite && mapped;
    assign rd_en = psel && penable && !pready && !pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    // Read data registered at the same edge that raises pready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (clk_en)
        begin
            prdata <= '0;
            if (rd_en)
            begin
                case (paddr)
                    epwm_pkg::OFF_MODULE_CONTROL:  prdata[7:0] <= module_control;
                    epwm_pkg::OFF_DUTY_HIGH_BYTE:  prdata[7:0] <= duty_high_byte;
                    epwm_pkg::OFF_PERIOD_REGISTER: prdata[TIMER_WIDTH-1:0] <= period_register;
                    epwm_pkg::OFF_PWM_CONTROL:     prdata[7:0] <= pwm_control;
                    epwm_pkg::OFF_SHUTDOWN_CTRL:
                        prdata[7:0] <= {shutdown_event_status, shutdown_setup};
                    epwm_pkg::OFF_TIMER_TWO_CTRL:  prdata[2:0] <= timer_two_control;
                    epwm_pkg::OFF_TIMER_TWO:       prdata[TIMER_WIDTH-1:0] <= timer_two;
                    epwm_pkg::OFF_PERIPH_FLAGS:
                        prdata[epwm_pkg::PF_TIMER_FLAG] <= timer_two_flag;
                    epwm_pkg::OFF_PORT_C_DIR:      prdata[3:0] <= port_c_direction;
                    epwm_pkg::OFF_CLOCK_STATUS:    prdata[0] <= backup_clock_select;
                    default:                       prdata <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Plain configuration registers
    // ------------------------------------------------------------
    // Every register returns to its default on any reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            module_control    <= epwm_pkg::RST_ZERO;             // see [RULE_02]
            duty_high_byte    <= epwm_pkg::RST_ZERO;
            period_register   <= TIMER_WIDTH'(epwm_pkg::RST_PERIOD);
            pwm_control       <= epwm_pkg::RST_ZERO;
            shutdown_setup    <= 7'h00;
            timer_two_control <= 3'h0;
            port_c_direction  <= epwm_pkg::RST_PORT_DIR;         // see [RULE_02]
        end
        else if (clk_en && wr_en)
        begin
            case (paddr)
                epwm_pkg::OFF_MODULE_CONTROL:  module_control  <= pwdata[7:0];
                epwm_pkg::OFF_DUTY_HIGH_BYTE:  duty_high_byte  <= pwdata[7:0];
                epwm_pkg::OFF_PERIOD_REGISTER: period_register <= pwdata[TIMER_WIDTH-1:0];
                epwm_pkg::OFF_PWM_CONTROL:     pwm_control     <= pwdata[7:0];
                epwm_pkg::OFF_SHUTDOWN_CTRL:   shutdown_setup  <= pwdata[6:0];
                epwm_pkg::OFF_TIMER_TWO_CTRL:  timer_two_control <= pwdata[2:0];
                epwm_pkg::OFF_PORT_C_DIR:      port_c_direction  <= pwdata[3:0];
                default:                       ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clock failure: source select reported to clock logic
    // ------------------------------------------------------------
    // Switching is sticky until reset so the unit never flips back
    // to a clock that has already misbehaved
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            backup_clock_select <= 1'b0;
        else if (fail_monitor_enable && primary_clock_fail)  // see [RULE_01]
            backup_clock_select <= 1'b1;
    end

    // ------------------------------------------------------------
    // Timer two and its overflow flag
    // ------------------------------------------------------------
    epwm_timer #(
        .WIDTH (TIMER_WIDTH)
    ) u_timer (
        .pclk         (pclk),
        .presetn      (presetn),
        .clk_en       (clk_en),
        .run          (timer_two_control[epwm_pkg::TC_RUN]),          // see [RULE_14]
        .prescale     (timer_two_control[epwm_pkg::TC_PRE_LSB +: 2]),
        .period       (period_register),
        .count        (timer_two),
        .fine         (fine),
        .period_start (period_start)
    );

    // An overflow in the same cycle as a clearing write still sets
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_two_flag <= 1'b0;
        else if (clk_en)
        begin
            if (period_start)
                timer_two_flag <= 1'b1;                              // see [RULE_15]
            else if (wr_en && is_off(epwm_pkg::OFF_PERIPH_FLAGS))
                timer_two_flag <= pwdata[epwm_pkg::PF_TIMER_FLAG];
        end
    end

    // ------------------------------------------------------------
    // Auto-shutdown
    // ------------------------------------------------------------
    // Source bits: 4 = external pin low, 2 = comparator 2, 1 = comparator 1
    always_comb
    begin
        shutdown_cond = (shutdown_setup[epwm_pkg::SC_SRC_LSB + 2]
                         && shutdown_sources.ext_pin_low)
                     || (shutdown_setup[epwm_pkg::SC_SRC_LSB + 1]
                         && shutdown_sources.comparator_2)
                     || (shutdown_setup[epwm_pkg::SC_SRC_LSB]
                         && shutdown_sources.comparator_1);       // see [RULE_10]
    end

    // Status: the condition sets it and blocks writes; auto-restart clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shutdown_event_status <= 1'b0;
        else if (clk_en)
        begin
            if (shutdown_cond)
                shutdown_event_status <= 1'b1;                       // see [RULE_19]
            else if (wr_en && is_off(epwm_pkg::OFF_SHUTDOWN_CTRL))
                shutdown_event_status <= pwdata[epwm_pkg::SC_STATUS]; // see [RULE_12]
            else if (pwm_control[epwm_pkg::PC_RESTART])
                shutdown_event_status <= 1'b0;                       // see [RULE_13]
        end
    end

    // Outputs stay shut until the period boundary after status clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= EPWM_RUN;
        else if (clk_en)
        begin
            case (state)
                EPWM_RUN:
                    if (shutdown_event_status || shutdown_cond)
                        state <= EPWM_SHUT;
                EPWM_SHUT:
                    if (!shutdown_event_status && !shutdown_cond)
                        state <= EPWM_ARMED;                         // see [RULE_18]
                EPWM_ARMED:
                    if (shutdown_event_status || shutdown_cond)
                        state <= EPWM_SHUT;
                    else if (period_start)
                        state <= EPWM_RUN;                           // see [RULE_18]
                default:
                    state <= EPWM_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Duty compare and output steering
    // ------------------------------------------------------------
    // PWM only when mode<3:2> = 11; the reset value keeps it off
    assign pwm_mode = (module_control[epwm_pkg::MC_MODE_LSB + 2 +: 2]
                       == epwm_pkg::PWM_MODE_TOP);                   // see [RULE_03]

    // Ten-bit duty against timer extended by the prescaler phase
    assign duty_on = {timer_two, fine}
                   < {duty_high_byte, module_control[epwm_pkg::MC_DCLOW_LSB +: 2]}; // see [RULE_08]

    epwm_steer #(
        .DEAD_WIDTH (DEAD_WIDTH)
    ) u_steer (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .active     (pwm_mode),
        .duty_on    (duty_on),
        .config_sel (module_control[epwm_pkg::MC_CONFIG_LSB +: 2]),
        .dead_band  (pwm_control[epwm_pkg::PC_DEAD_LSB +: DEAD_WIDTH]),
        .level      (level)
    );

    // Polarity per pair, then direction bits, then shutdown levels and tri-state override both
    always_comb
    begin
        next_out.output_pin_a = level.output_pin_a ^ module_control[1];  // see [RULE_07]
        next_out.output_pin_c = level.output_pin_c ^ module_control[1];
        next_out.output_pin_b = level.output_pin_b ^ module_control[0];
        next_out.output_pin_d = level.output_pin_d ^ module_control[0];
        next_oe = ~epwm_pkg::epwm_pins_type'(port_c_direction);
        if (!pwm_mode)
            next_out = '0;
        else if (state != EPWM_RUN)                                      // see [RULE_12]
        begin
            next_out.output_pin_a = pair_state(shutdown_setup, epwm_pkg::SC_AC_LSB) == 2'h1;
            next_out.output_pin_c = next_out.output_pin_a;               // see [RULE_11]
            next_out.output_pin_b = pair_state(shutdown_setup, epwm_pkg::SC_BD_LSB) == 2'h1;
            next_out.output_pin_d = next_out.output_pin_b;
            if (pair_state(shutdown_setup, epwm_pkg::SC_AC_LSB) >= 2'h2)
            begin
                next_oe.output_pin_a = 1'b0;
                next_oe.output_pin_c = 1'b0;
            end
            if (pair_state(shutdown_setup, epwm_pkg::SC_BD_LSB) >= 2'h2)
            begin
                next_oe.output_pin_b = 1'b0;
                next_oe.output_pin_d = 1'b0;
            end
        end
    end

    // Pins come up as inputs and driven low after any reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= '0;
            pin_oe  <= '0;                                               // see [RULE_02]
        end
        else if (clk_en)
        begin
            pin_out <= next_out;
            pin_oe  <= next_oe;                                          // see [RULE_04]
        end
    end
endmodule

// ==== bench/epwm_checker.sv ====
module epwm_checker (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    clk_en,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [7:0]              paddr,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    fail_monitor_enable,
    input wire logic                    primary_clock_fail,
    input wire logic                    backup_clock_select,
    input wire epwm_pkg::epwm_pins_type pin_oe,
    input wire logic                    timer_two_flag
);
    // -------------------------------------------
    // Port relations
    // -------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // First access edge of a transfer
    sequence s_first_access;
        psel && penable && !pready && clk_en;
    endsequence
    a_one_wait: assert property (s_first_access |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("prdata not zero");
    a_backup_sticky: assert property (backup_clock_select |=> backup_clock_select)
        else $error("backup dropped");
    a_backup_cause: assert property (fail_monitor_enable && primary_clock_fail
        |-> ##[1:2] backup_clock_select)
        else $error("backup not taken");
    a_flag_held: assert property (timer_two_flag
        && !(psel && pwrite && paddr == 8'h1C) |=> timer_two_flag)
        else $error("flag lost");
    a_oe_reset: assert property ($rose(presetn) |-> pin_oe == '0 ##1 pin_oe == '0)
        else $error("pins driven after reset");
endmodule

bind epwm_unit epwm_checker chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fail_monitor_enable(fail_monitor_enable),
    .primary_clock_fail(primary_clock_fail), .backup_clock_select(backup_clock_select),
    .pin_oe(pin_oe), .timer_two_flag(timer_two_flag));

// ==== bench/tb_enhanced_pwm_setup_control.sv ====
module tb_enhanced_pwm_setup_control;
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------
    // Stimulus, model and checks
    // -------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fme, pcf, bsel, tflag, ce;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        e;
    epwm_pkg::epwm_sources_type src;
    epwm_pkg::epwm_pins_type    pout, poe;
    int errors, n_tests, t;
    int mdl[10] = '{0, 0, 255, 0, 0, 0, 0, 0, 15, 0};
    int idx[6] = '{0, 1, 2, 3, 5, 4};
    int msk[6] = '{255, 255, 255, 255, 3, 127};
    epwm_unit dut_u (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .shutdown_sources(src), .fail_monitor_enable(fme),
        .primary_clock_fail(pcf), .backup_clock_select(bsel), .pin_out(pout), .pin_oe(poe),
        .timer_two_flag(tflag));
    task automatic conclude();
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Setup, access until pready, one idle edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) errors++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Generous bound on run length
    initial
    begin
        #20000;
        errors++;
        conclude();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, src, fme, pcf} = '0;
        ce = 1'b1;
        void'($urandom(32'h3CF6));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 10; i++) rd(8'(i * 4), mdl[i]);
        foreach (idx[i])
        begin
            mdl[idx[i]] = $urandom & msk[i];
            xfer(1'b1, 8'(idx[i] * 4), 32'(mdl[idx[i]]));
            rd(8'(idx[i] * 4), mdl[idx[i]]);
        end
        xfer(1'b1, 8'h40, 32'h5A);
        chk(e, 1'b1);
        xfer(1'b1, 8'h08, 32'h03);
        xfer(1'b1, 8'h14, 32'h04);
        xfer(1'b1, 8'h1C, 32'h00);
        for (t = 0; tflag !== 1'b1 && t < 12; t++) @(posedge pclk);
        chk(t < 12, 1'b1);
        xfer(1'b1, 8'h14, 32'h00);
        rd(8'h1C, 32'h02);
        xfer(1'b1, 8'h1C, 32'h00);
        rd(8'h1C, 32'h00);
        xfer(1'b1, 8'h20, 32'h00);
        xfer(1'b1, 8'h00, 32'h0C);
        xfer(1'b1, 8'h0C, 32'h00);
        xfer(1'b1, 8'h10, 32'h44);
        src.ext_pin_low <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(8'h10, 32'hC4);
        chk(pout.output_pin_a, 1'b1);
        xfer(1'b1, 8'h10, 32'h44);
        rd(8'h10, 32'hC4);
        xfer(1'b1, 8'h0C, 32'h80);
        src.ext_pin_low <= 1'b0;
        repeat (3) @(posedge pclk);
        rd(8'h10, 32'h44);
        chk(pout.output_pin_c, 1'b1);
        xfer(1'b1, 8'h14, 32'h04);
        xfer(1'b1, 8'h10, 32'h14);
        @(posedge pclk);
        ce <= 1'b0;
        src.comparator_1 <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(pout.output_pin_c, 1'b0);
        ce <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(pout.output_pin_c, 1'b1);
        fme <= 1'b1;
        pcf <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(bsel, 1'b1);
        conclude();
    end
endmodule
